// file: rtl/swh_regs.svh
// constants and timing counts for the sweep mode and holdoff logic
// Functional notes
// - enabled qualifying trigger drives received pair
// - received trigger: sense high, gate opens
// - no trigger: low sense pulse starts sweep
// - triggered-only mode: sweeps start on triggers
// - free-run selected by active-low select
// - trigger restarts timeout, suppresses auto drive
// - timeout expiry asserts auto drive
// - one-shot blocks sweeps until reset
// - ready shows sweep armed for trigger
// - holdoff start raises disable; one-shot keeps it
// - either reset low re-arms the sweep
// - sweep stop starts holdoff, disable high
// - disable held until adjustable holdoff elapses
// - high lockout disables the sweep
// - lockout also starts a holdoff cycle
// - dual-delay divider toggles per holdoff end
// - dual-delay passes every second holdoff out
// - delayed-start forces divider, every holdoff out
// - holdoff output high during holdoff while divider clear
// - standalone inhibits both pickoff comparators
// - single-delay with separation control off inhibits only second comparator
// - dual-delay inhibits comparators alternately, low active
`ifndef SWH_REGS_SVH
`define SWH_REGS_SVH

`define SWH_CLK_HZ        40000000
`define SWH_TIMEOUT_US    100000
`define SWH_TIMEOUT_CYC   (`SWH_TIMEOUT_US * (`SWH_CLK_HZ / 1000000))
`define SWH_HO_UNIT_NS    1000
`define SWH_HO_UNIT_CYC   ((`SWH_HO_UNIT_NS * (`SWH_CLK_HZ / 1000000) + 999) / 1000)
`define SWH_KNOB_W        4
`define SWH_TO_W          22
`define SWH_HO_W          10
`define SWH_SYNC_RST      1'b0
`define SWH_DIV_RST       1'b0

`endif

// file: rtl/swh_pkg.sv
// types shared by the sweep mode and holdoff logic
`default_nettype none
package swh_pkg;
	// gray order along armed, sweep, holdoff, spent
	typedef enum logic [1:0] {
		SWH_ARMED   = 2'h0,
		SWH_SWEEP   = 2'h1,
		SWH_HOLDOFF = 2'h3,
		SWH_SPENT   = 2'h2
	} swh_state_t;
endpackage
`default_nettype wire

// file: rtl/swh_sync.sv
// three-stage pin synchroniser, output moves when stages two and three agree
`default_nettype none
`include "swh_regs.svh"
module swh_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_b_i,
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] sync_o
);
	import swh_pkg::*;

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] out;
	} swh_sync_st_t;

	swh_sync_st_t q_r;
	swh_sync_st_t q_nxt;

	always_comb begin
		q_nxt     = q_r;
		q_nxt.s1  = pin_i;
		q_nxt.s2  = q_r.s1;
		q_nxt.s3  = q_r.s2;
		// a lone glitch between stages two and three is not passed on
		q_nxt.out = (q_r.s2 & q_r.s3) | (q_r.out & (q_r.s2 | q_r.s3));
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			q_r <= {(4 * W){`SWH_SYNC_RST}};
		end else begin
			q_r <= q_nxt;
		end
	end

	assign sync_o = q_r.out;
endmodule
`default_nettype wire

// file: rtl/swh_sweep_logic.sv
// sweep start, auto, one-shot, holdoff and pickoff inhibit logic
`default_nettype none
`include "swh_regs.svh"
module swh_sweep_logic #(
	parameter int KNOB_W  = `SWH_KNOB_W,
	parameter int TO_W    = `SWH_TO_W,
	parameter int HO_W    = `SWH_HO_W,
	parameter int TO_CYC  = `SWH_TIMEOUT_CYC,
	parameter int HO_UNIT = `SWH_HO_UNIT_CYC
) (
	input  wire logic              clk_i,
	input  wire logic              rst_b_i,
	input  wire logic              trig_det_i,
	input  wire logic              trig_en_b_i,
	input  wire logic              triggered_only_mode_b_i,
	input  wire logic              free_run_b_i,
	input  wire logic              one_shot_mode_i,
	input  wire logic              reset_btn_b_i,
	input  wire logic              remote_reset_b_i,
	input  wire logic              sweep_stop_i,
	input  wire logic              lockout_i,
	input  wire logic              dual_delay_i,
	input  wire logic              standalone_i,
	input  wire logic              trace_separation_control_off_i,
	input  wire logic [KNOB_W-1:0] holdoff_knob_i,
	output logic                   trig_rcvd_o,
	output logic                   trig_rcvd_b_o,
	output logic                   auto_sense_o,
	output logic                   sweep_gate_o,
	output logic                   unblank_b_o,
	output logic                   auto_drive_o,
	output logic                   ready_o,
	output logic                   sweep_dis_o,
	output logic                   holdoff_b_o,
	output logic                   holdoff_o,
	output logic                   pickoff1_inh_b_o,
	output logic                   pickoff2_inh_b_o,
	output swh_pkg::swh_state_t    state_o
);
	import swh_pkg::*;

	localparam int SW = 12 + KNOB_W;

	typedef struct packed {
		swh_state_t      st;
		logic [TO_W-1:0] to_cnt;
		logic [HO_W-1:0] ho_cnt;
		logic            div;
		logic            stop_q;
		logic            trig_rcvd;
		logic            trig_rcvd_b;
		logic            auto_sense;
		logic            sweep_gate;
		logic            unblank_b;
		logic            auto_drive;
		logic            ready;
		logic            sweep_dis;
		logic            holdoff_b;
		logic            holdoff;
		logic            pk1_b;
		logic            pk2_b;
	} swh_st_t;

	swh_st_t q_r;
	swh_st_t q_nxt;

	logic [SW-1:0]     pins;
	logic [SW-1:0]     s;
	logic              s_trig;
	logic              s_en_b;
	logic              s_triggered_only_mode_b;
	logic              s_free_b;
	logic              s_one;
	logic              s_rst_btn_b;
	logic              s_rst_rem_b;
	logic              s_stop;
	logic              s_lock;
	logic              s_dual;
	logic              s_alone;
	logic              s_sep_off;
	logic [KNOB_W-1:0] s_knob;
	logic              trig;
	logic              auto_mode;
	logic              stop_rise;
	logic              rst_req;
	logic              ho_fall;

	assign pins = {trig_det_i, trig_en_b_i, triggered_only_mode_b_i, free_run_b_i,
		one_shot_mode_i, reset_btn_b_i, remote_reset_b_i, sweep_stop_i, lockout_i,
		dual_delay_i, standalone_i, trace_separation_control_off_i, holdoff_knob_i};

	swh_sync #(
		.W (SW)
	) u_sync (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.pin_i   (pins),
		.sync_o  (s)
	);

	assign {s_trig, s_en_b, s_triggered_only_mode_b, s_free_b, s_one, s_rst_btn_b, s_rst_rem_b,
		s_stop, s_lock, s_dual, s_alone, s_sep_off, s_knob} = s;

	// holdoff length grows with the panel control, never below one unit
	function automatic logic [HO_W-1:0] ho_load(input logic [KNOB_W-1:0] knob);
		int unsigned len;
		len = HO_UNIT * (int'(knob) + 1) - 1;
		return HO_W'(len);
	endfunction

	assign trig      = s_trig & ~s_en_b;
	assign auto_mode = ~s_free_b & s_triggered_only_mode_b;
	assign stop_rise = s_stop & ~q_r.stop_q;
	assign rst_req   = ~s_rst_btn_b | ~s_rst_rem_b;

	always_comb begin
		q_nxt        = q_r;
		q_nxt.stop_q = s_stop;
		q_nxt.trig_rcvd   = trig;
		q_nxt.trig_rcvd_b = ~trig;
		// sense high unless auto pulse below
		q_nxt.auto_sense  = 1'b1;

		if (trig || !auto_mode) begin
			q_nxt.to_cnt     = '0;
			q_nxt.auto_drive = 1'b0;
		end else if (q_r.to_cnt == TO_W'(TO_CYC - 1)) begin
			q_nxt.auto_drive = 1'b1;
		end else begin
			q_nxt.to_cnt = q_r.to_cnt + 1'b1;
		end

		unique case (q_r.st)
			SWH_ARMED: begin
				if (s_lock) begin
					q_nxt.st     = SWH_HOLDOFF;
					q_nxt.ho_cnt = ho_load(s_knob);
				end else if (trig) begin
					q_nxt.st = SWH_SWEEP;
				// auto start with low sense pulse
				end else if (q_r.auto_drive) begin
					q_nxt.st         = SWH_SWEEP;
					q_nxt.auto_sense = 1'b0;
				end
			end
			SWH_SWEEP: begin
				if (s_lock || stop_rise) begin
					q_nxt.st     = SWH_HOLDOFF;
					q_nxt.ho_cnt = ho_load(s_knob);
				end
			end
			SWH_HOLDOFF: begin
				if (s_lock) begin
					q_nxt.ho_cnt = ho_load(s_knob);
				end else if (q_r.ho_cnt == '0) begin
					q_nxt.st = s_one ? SWH_SPENT : SWH_ARMED;
				end else begin
					q_nxt.ho_cnt = q_r.ho_cnt - 1'b1;
				end
			end
			SWH_SPENT: begin
				if (s_lock) begin
					q_nxt.st     = SWH_HOLDOFF;
					q_nxt.ho_cnt = ho_load(s_knob);
				end else if (rst_req) begin
					q_nxt.st = SWH_ARMED;
				end
			end
		endcase

		q_nxt.sweep_gate = (q_nxt.st == SWH_SWEEP);
		q_nxt.unblank_b  = (q_nxt.st != SWH_SWEEP);
		q_nxt.sweep_dis  = (q_nxt.st == SWH_HOLDOFF) || (q_nxt.st == SWH_SPENT) || s_lock;
		q_nxt.holdoff_b  = (q_nxt.st != SWH_HOLDOFF);
		q_nxt.ready      = (q_nxt.st == SWH_ARMED) && !s_lock;

		ho_fall = (q_r.st == SWH_HOLDOFF) && (q_nxt.st != SWH_HOLDOFF);
		if (!s_dual) begin
			q_nxt.div = 1'b0;
		end else if (ho_fall) begin
			q_nxt.div = ~q_r.div;
		end
		q_nxt.holdoff = (q_nxt.st == SWH_HOLDOFF) && !q_nxt.div;

		if (s_alone) begin
			q_nxt.pk1_b = 1'b0;
			q_nxt.pk2_b = 1'b0;
		end else if (s_dual) begin
			q_nxt.pk1_b = ~q_nxt.div;
			q_nxt.pk2_b = q_nxt.div;
		end else if (s_sep_off) begin
			q_nxt.pk1_b = 1'b1;
			q_nxt.pk2_b = 1'b0;
		end else begin
			q_nxt.pk1_b = 1'b1;
			q_nxt.pk2_b = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			q_r             <= '0;
			q_r.st          <= SWH_ARMED;
			q_r.div         <= `SWH_DIV_RST;
			q_r.trig_rcvd_b <= 1'b1;
			q_r.auto_sense  <= 1'b1;
			q_r.unblank_b   <= 1'b1;
			q_r.holdoff_b   <= 1'b1;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign trig_rcvd_o      = q_r.trig_rcvd;
	assign trig_rcvd_b_o    = q_r.trig_rcvd_b;
	assign auto_sense_o     = q_r.auto_sense;
	assign sweep_gate_o     = q_r.sweep_gate;
	assign unblank_b_o      = q_r.unblank_b;
	assign auto_drive_o     = q_r.auto_drive;
	assign ready_o          = q_r.ready;
	assign sweep_dis_o      = q_r.sweep_dis;
	assign holdoff_b_o      = q_r.holdoff_b;
	assign holdoff_o        = q_r.holdoff;
	assign pickoff1_inh_b_o = q_r.pk1_b;
	assign pickoff2_inh_b_o = q_r.pk2_b;
	assign state_o          = q_r.st;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	sequence seq_armed_idle;
		q_r.st == SWH_ARMED && !s_lock;
	endsequence

	sequence seq_ho_end;
		q_r.st == SWH_HOLDOFF && !s_lock && q_r.ho_cnt == '0;
	endsequence

	chk_trig_pair: assert property (
		trig |=> trig_rcvd_o && !trig_rcvd_b_o)
		else $error("trigger-received pair wrong");

	chk_trig_gate: assert property (
		seq_armed_idle and trig |=> sweep_gate_o && !unblank_b_o && auto_sense_o)
		else $error("trigger did not open the sweep gate");

	chk_auto_pulse: assert property (
		seq_armed_idle and (!trig && auto_drive_o)
		|=> !auto_sense_o && sweep_gate_o ##1 auto_sense_o)
		else $error("auto sense pulse wrong");

	chk_triggered_only_mode_noauto: assert property (
		!s_triggered_only_mode_b |=> !auto_drive_o)
		else $error("auto drive in triggered-only mode");

	chk_trig_supp: assert property (
		trig |=> !auto_drive_o && q_r.to_cnt == '0)
		else $error("trigger did not restart timeout");

	chk_auto_expiry: assert property (
		auto_mode && !trig && q_r.to_cnt == TO_W'(TO_CYC - 1) |=> auto_drive_o)
		else $error("auto drive missing after timeout");

	chk_one_shot: assert property (
		q_r.st == SWH_SPENT && !rst_req && !s_lock |=> q_r.st == SWH_SPENT && sweep_dis_o)
		else $error("one-shot sweep rearmed without reset");

	chk_reset_arm: assert property (
		q_r.st == SWH_SPENT && rst_req && !s_lock |=> ready_o && !sweep_dis_o)
		else $error("reset did not rearm");

	chk_stop_ho: assert property (
		q_r.st == SWH_SWEEP && stop_rise
		|=> (sweep_dis_o && !holdoff_b_o)[*2])
		else $error("sweep stop did not hold off");

	chk_ho_release: assert property (
		seq_ho_end |=> q_r.st != SWH_HOLDOFF && sweep_dis_o == $past(s_one))
		else $error("holdoff release wrong");

	chk_lockout: assert property (
		s_lock |=> sweep_dis_o && !sweep_gate_o && !ready_o)
		else $error("lockout did not disable sweep");

	chk_div_toggle: assert property (
		s_dual && $past(s_dual) && q_r.st == SWH_ARMED && $past(q_r.st) == SWH_HOLDOFF
		|-> q_r.div != $past(q_r.div))
		else $error("divider did not toggle");

	chk_forced_open: assert property (
		!s_dual |=> !q_r.div)
		else $error("divider not forced open");

	chk_alone_inh: assert property (
		s_alone |=> !pickoff1_inh_b_o && !pickoff2_inh_b_o)
		else $error("standalone pickoffs not inhibited");

	chk_alt_inh: assert property (
		s_dual && !s_alone |=> pickoff1_inh_b_o != pickoff2_inh_b_o)
		else $error("dual pickoffs not complementary");

	chk_free_count: assert property (
		auto_mode && !trig && q_r.to_cnt != TO_W'(TO_CYC - 1)
		|=> q_r.to_cnt == $past(q_r.to_cnt) + 1'b1)
		else $error("free-run timeout not counting");

	chk_ready_armed: assert property (
		seq_armed_idle and (!trig && !auto_drive_o) |=> ready_o && q_r.st == SWH_ARMED)
		else $error("ready missing while armed");

	chk_lock_ho: assert property (
		s_lock |=> q_r.st == SWH_HOLDOFF && q_r.ho_cnt == ho_load($past(s_knob)))
		else $error("lockout did not start holdoff");

	chk_div_end: assert property (
		seq_ho_end and s_dual |=> q_r.div != $past(q_r.div))
		else $error("divider missed a holdoff end");

	chk_ho_out: assert property (
		holdoff_o |-> q_r.st == SWH_HOLDOFF && !holdoff_b_o)
		else $error("holdoff output outside holdoff");

	chk_single_inh: assert property (
		!s_alone && !s_dual && s_sep_off |=> pickoff1_inh_b_o && !pickoff2_inh_b_o)
		else $error("single-delay pickoffs wrong");
endmodule
`default_nettype wire

// file: verif/swh_ramp_model.sv
// far-side ramp comparator and mainframe lockout model for the sweep bench
`default_nettype none
module swh_ramp_model #(
	parameter int RAMP = 10
) (
	input  wire logic clk_i,
	input  wire logic sweep_gate_i,
	input  wire logic lock_req_i,
	output logic      sweep_stop_o,
	output logic      lockout_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int ramp_cnt = 0;
	// mainframe lockout level, follows the bench request directly
	assign lockout_o = lock_req_i;
	always @(negedge clk_i) begin
		ramp_cnt <= sweep_gate_i ? ramp_cnt + 1 : 0;
		// stop pulse at ramp end
		// held until the gate drops, as the analog comparator would
		sweep_stop_o <= sweep_gate_i && (ramp_cnt >= RAMP);
	end
endmodule
`default_nettype wire

// file: verif/swh_sweep_logic_tb.sv
// self-checking bench for the sweep mode and holdoff logic
`default_nettype none
module swh_sweep_logic_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import swh_pkg::*;
	localparam int TO_CYC = 50;
	localparam int HO_UNIT = 2;
	logic       clk_i, rst_b_i, trig_det, trig_en_b, trig_only_b, free_run_b, one_shot;
	logic       rst_btn_b, rmt_rst_b, stop, lockout, lock_req, dual, standalone, sep_off;
	logic [3:0] knob;
	logic       rcvd, rcvd_b, sense, gate, unblank_b, auto_drv, ready, dis, ho_b, ho;
	logic       pk1_b, pk2_b, prev_ho, seen_auto, seen_sense;
	swh_state_t state;
	int         cyc, failures, checks, hb_falls, ho_rises, ho_run, ho_len, n_out;

	swh_sweep_logic #(.TO_CYC(TO_CYC), .HO_UNIT(HO_UNIT)) dut_u (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .trig_det_i(trig_det), .trig_en_b_i(trig_en_b),
		.triggered_only_mode_b_i(trig_only_b), .free_run_b_i(free_run_b),
		.one_shot_mode_i(one_shot), .reset_btn_b_i(rst_btn_b), .remote_reset_b_i(rmt_rst_b),
		.sweep_stop_i(stop), .lockout_i(lockout), .dual_delay_i(dual),
		.standalone_i(standalone), .trace_separation_control_off_i(sep_off),
		.holdoff_knob_i(knob), .trig_rcvd_o(rcvd), .trig_rcvd_b_o(rcvd_b),
		.auto_sense_o(sense), .sweep_gate_o(gate), .unblank_b_o(unblank_b),
		.auto_drive_o(auto_drv), .ready_o(ready), .sweep_dis_o(dis), .holdoff_b_o(ho_b),
		.holdoff_o(ho), .pickoff1_inh_b_o(pk1_b), .pickoff2_inh_b_o(pk2_b), .state_o(state));

	swh_ramp_model #(.RAMP(10)) ramp_u (.clk_i(clk_i), .sweep_gate_i(gate),
		.lock_req_i(lock_req), .sweep_stop_o(stop), .lockout_o(lockout));

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	task automatic conclude();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// edge and run-length monitors, plus the hang limit
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		prev_ho <= ho;
		if (auto_drv === 1'b1) seen_auto <= 1'b1;
		if (sense === 1'b0) seen_sense <= 1'b1;
		if (ho === 1'b1 && prev_ho === 1'b0) ho_rises <= ho_rises + 1;
		if (ho_b === 1'b0) begin
			if (ho_run == 0) hb_falls <= hb_falls + 1;
			ho_run <= ho_run + 1;
		end else if (ho_run != 0) begin
			ho_len <= ho_run;
			ho_run <= 0;
		end
		if (cyc == 20000) begin
			failures++;
			conclude();
		end
	end

	task automatic chk(input string name, input logic [1:0] exp, input logic [1:0] got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_n(input string name, input int exp, input int got);
		checks++;
		if (got != exp) begin
			failures++;
			$display("BAD %s expected %0d seen %0d", name, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	task automatic wait_state(input swh_state_t s, input int lim);
		int i;
		i = 0;
		while (state !== s && i < lim) begin
			@(negedge clk_i);
			i++;
		end
		chk("state", s, state);
	endtask

	// trigger held high until n holdoffs have begun; reports holdoff outputs seen
	task automatic run_holdoffs(input int n, output int outs);
		int i, h0, o0;
		i = 0;
		h0 = hb_falls;
		o0 = ho_rises;
		trig_det = 1'b1;
		while (hb_falls - h0 < n && i < 2000) begin
			@(negedge clk_i);
			i++;
		end
		trig_det = 1'b0;
		tick(40);
		outs = ho_rises - o0;
	endtask

	initial begin
		{rst_b_i, trig_det, trig_en_b, trig_only_b, one_shot, lock_req, free_run_b} = '0;
		{rst_btn_b, rmt_rst_b} = '1;
		{dual, standalone, sep_off, seen_auto, seen_sense} = '0;
		{cyc, failures, checks, hb_falls, ho_rises, ho_run, ho_len} = '0;
		prev_ho = 1'b0;
		knob = 4'h3;
		tick(6);
		chk("state_rst", SWH_ARMED, state);
		chk("hob_rst", 2'h1, ho_b);
		rst_b_i = 1'b1;
		tick(TO_CYC * 2);
		chk("gate_idle", 2'h0, gate);
		chk("auto_idle", 2'h0, seen_auto);
		chk("ready", 2'h1, ready);
		// trigger present but stage disabled
		{trig_en_b, trig_det} = 2'h3;
		tick(12);
		chk("rcvd_off", 2'h0, rcvd);
		chk("rcvd_b_off", 2'h1, rcvd_b);
		chk("gate_off", 2'h0, gate);
		{trig_en_b, trig_det} = 2'h0;
		// short and long holdoff settings
		for (int k = 0; k < 2; k++) begin
			knob = (k == 0) ? 4'h0 : 4'hF;
			tick(6);
			trig_det = 1'b1;
			wait_state(SWH_SWEEP, 12);
			tick(1);
			chk("rcvd", 2'h1, rcvd);
			chk("rcvd_b", 2'h0, rcvd_b);
			chk("gate", 2'h1, gate);
			chk("unblank_b", 2'h0, unblank_b);
			chk("sense", 2'h1, sense);
			chk("ready_sw", 2'h0, ready);
			trig_det = 1'b0;
			wait_state(SWH_HOLDOFF, 30);
			tick(1);
			chk("dis_ho", 2'h1, dis);
			chk("hob_ho", 2'h0, ho_b);
			chk("ho_out", 2'h1, ho);
			wait_state(SWH_ARMED, 60);
			tick(1);
			chk_n("ho_len", HO_UNIT * (int'(knob) + 1), ho_len);
			chk("dis_end", 2'h0, dis);
			chk("ready_end", 2'h1, ready);
		end
		// free-run with no trigger, then with frequent triggers
		{trig_only_b, free_run_b, seen_auto, seen_sense} = 4'h8;
		wait_state(SWH_SWEEP, TO_CYC + 40);
		chk("rcvd_auto", 2'h0, rcvd);
		tick(2);
		chk("auto_seen", 2'h1, seen_auto);
		chk("sense_pulse", 2'h1, seen_sense);
		for (int p = 0; p < 12; p++) begin
			if (p == 3) seen_auto = 1'b0;
			trig_det = 1'b1;
			tick(4);
			trig_det = 1'b0;
			tick(16);
		end
		chk("auto_held", 2'h0, seen_auto);
		{trig_only_b, free_run_b, one_shot, knob} = {3'h3, 4'h3};
		tick(60);
		// one-shot, released by panel then by remote reset
		for (int r = 0; r < 2; r++) begin
			trig_det = 1'b1;
			wait_state(SWH_SPENT, 80);
			tick(30);
			chk("spent", SWH_SPENT, state);
			chk("dis_spent", 2'h1, dis);
			chk("ready_spent", 2'h0, ready);
			trig_det = 1'b0;
			if (r == 0) rst_btn_b = 1'b0;
			else rmt_rst_b = 1'b0;
			tick(4);
			{rst_btn_b, rmt_rst_b} = 2'h3;
			wait_state(SWH_ARMED, 12);
			tick(1);
			chk("dis_rearm", 2'h0, dis);
			chk("ready_rearm", 2'h1, ready);
		end
		one_shot = 1'b0;
		lock_req = 1'b1;
		tick(9);
		chk("dis_lock", 2'h1, dis);
		chk("ready_lock", 2'h0, ready);
		chk("state_lock", SWH_HOLDOFF, state);
		chk("hob_lock", 2'h0, ho_b);
		lock_req = 1'b0;
		wait_state(SWH_ARMED, 60);
		standalone = 1'b1;
		tick(8);
		chk("pk1_alone", 2'h0, pk1_b);
		chk("pk2_alone", 2'h0, pk2_b);
		{standalone, sep_off} = 2'h1;
		tick(8);
		chk("pk1_single", 2'h1, pk1_b);
		chk("pk2_single", 2'h0, pk2_b);
		run_holdoffs(4, n_out);
		chk_n("ho_every", 4, n_out);
		{sep_off, dual} = 2'h1;
		tick(8);
		run_holdoffs(4, n_out);
		chk_n("ho_half", 2, n_out);
		chk("pk_alt", {1'b0, ~pk2_b}, {1'b0, pk1_b});
		conclude();
	end
endmodule
`default_nettype wire
